// [logic/sfs_consts.svh]
// Purpose: constants of the serial flash status and framing front end
// Assumes: 25 MHz system clock; serial pins sampled by that clock
// Notes: opcodes, field reset values and timing counts
// Notes on behaviour
// - Guard 00 or 01 with pin high: need latch
// - Guard 10 locks writes until next power cycle
// - Guard 11 locks status register for good
// - Quad enable turns extra pins into data lines
// - Three one-time lock bits, set individually only
// - Complement bit defaults zero, joins range bits
// - Suspend sets erase or program paused flag
// - Resume or power cycle clears paused flags
// - Scheme bit picks range or block locks
// - Block locks all set at power-on, reset
// - Drive strength field, default fifty percent
// - Role bit picks pause or reset pin
// - Pin roles only while quad enable clear
// - Bits latched MSB first on clock rise
// - Transaction starts with single command byte
// - Read data follows command; host may stop
// - Write-type commands need byte-aligned chip select
// - Partial program byte: nothing, latch stays set
// - Status bytes read and written by opcode
// - No write-type command without write latch
// - Busy bit high during program, erase, write
// - Chip erase only with low range, complement zero
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// Command opcodes
`define SFS_OP_WREN      8'h06
`define SFS_OP_WRDI      8'h04
`define SFS_OP_RDSR_LO   8'h05
`define SFS_OP_RDSR_MID  8'h35
`define SFS_OP_RDSR_HI   8'h15
`define SFS_OP_WRSR_LO   8'h01
`define SFS_OP_WRSR_MID  8'h31
`define SFS_OP_WRSR_HI   8'h11
`define SFS_OP_READ      8'h03
`define SFS_OP_FAST_READ 8'h0B
`define SFS_OP_PROGRAM   8'h02
`define SFS_OP_ERASE_4K  8'h20
`define SFS_OP_ERASE_32K 8'h52
`define SFS_OP_ERASE_64K 8'hD8
`define SFS_OP_CHIP_A    8'h60
`define SFS_OP_CHIP_B    8'hC7
`define SFS_OP_DEEP_PD   8'hB9
`define SFS_OP_WAKE      8'hAB
`define SFS_OP_SUSPEND   8'h75
`define SFS_OP_RESUME    8'h7A

// Byte counts within a frame, command byte included
`define SFS_IDX_ADDR_LAST 3'h3
`define SFS_IDX_ADDR_DONE 3'h4
`define SFS_IDX_DUMMY     3'h4
`define SFS_IDX_FAST_DATA 3'h5
`define SFS_IDX_WRSR_DONE 3'h2

// Reset values of status fields, block lock and pin synchronisers
`define SFS_GUARD_RESET      2'h0
`define SFS_DRV_RESET        2'h2
`define SFS_QE_RESET         1'b0
`define SFS_CMP_RESET        1'b0
`define SFS_LB_RESET         3'h0
`define SFS_BLOCK_LOCK_RESET 1'b1
`define SFS_SYNC_RESET       5'h13

// Timing
`define SFS_CLK_PERIOD_NS 40
`define SFS_SR_WRITE_NS   5000
`define SFS_SR_WRITE_CYC  ((`SFS_SR_WRITE_NS + `SFS_CLK_PERIOD_NS - 1) / `SFS_CLK_PERIOD_NS)

`endif

// [logic/sfs_pkg.sv]
// Purpose: types of the serial flash status and framing front end
// Assumes: nothing beyond plain SystemVerilog
// Notes: status struct lists bits 23 down to 0
package sfs_pkg;

  // Full 24-bit status image, high byte first
  typedef struct packed {
    logic       hold_reset_sel;
    logic [1:0] drive_strength_field;
    logic [1:0] rsv_hi;
    logic       protect_scheme_select;
    logic [1:0] rsv_lo;
    logic       erase_paused_flag;
    logic       protect_complement;
    logic [2:0] secure_area_lock_bits;
    logic       program_paused_flag;
    logic       four_lane_enable;
    logic       sr_guard_high;
    logic       sr_guard_low;
    logic [4:0] protect_range_bits;
    logic       write_latch;
    logic       write_busy_flag;
  } sfs_status_t;

  // Protection settings handed to the array
  typedef struct packed {
    logic       scheme;
    logic       complement;
    logic [4:0] range;
    logic [2:0] secure_lock;
    logic       block_lock_all;
  } sfs_prot_t;

  typedef enum logic [2:0] {
    OPK_NONE      = 3'h0,
    OPK_PROG      = 3'h1,
    OPK_ERASE_4K  = 3'h2,
    OPK_ERASE_32K = 3'h3,
    OPK_ERASE_64K = 3'h4,
    OPK_CHIP      = 3'h5,
    OPK_SUSPEND   = 3'h6,
    OPK_RESUME    = 3'h7
  } sfs_op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CMD  = 3'h2,
    ST_BODY = 3'h4
  } sfs_state_t;

endpackage

// [logic/sfs_shift.sv]
// Purpose: serial bit shifter, input on rise, output on fall
// Assumes: rise and fall are one-cycle pulses from the same clock
// Notes: count wraps every eight bits, cleared outside a frame
`timescale 1ns/1ps
module sfs_shift (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       active,
  input  wire logic       rise,
  input  wire logic       fall,
  input  wire logic       si,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            byte_done,
  output logic      [2:0] bit_cnt,
  output logic            tx_bit
);
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic       done_r, done_nxt;

  // Next shift state
  always_comb begin
    rx_nxt   = rx_r;
    tx_nxt   = tx_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (!active) begin
      cnt_nxt = 3'h0;
    end else begin
      if (rise) begin
        rx_nxt   = {rx_r[6:0], si};            // MSB first
        cnt_nxt  = 3'(cnt_r + 3'h1);
        done_nxt = (cnt_r == 3'h7);
      end
      if (fall) begin
        if (cnt_r == 3'h0) begin
          tx_nxt = tx_byte;
        end else begin
          tx_nxt = {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // Register shift state
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_r   <= 8'h00;
      tx_r   <= 8'h00;
      cnt_r  <= 3'h0;
      done_r <= 1'b0;
    end else begin
      rx_r   <= rx_nxt;
      tx_r   <= tx_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign rx_byte   = rx_r;
  assign byte_done = done_r;
  assign bit_cnt   = cnt_r;
  assign tx_bit    = tx_r[7];

  chk_bit_count_step: assert property (@(posedge clk) disable iff (srst)
    (active && rise) |=> (bit_cnt == 3'($past(bit_cnt) + 3'h1)))
    else $error("bit count did not advance on clock rise");

endmodule

// [logic/sfs_top.sv]
// Purpose: serial command framing and status protection of a NOR flash
// Assumes: host drives chip select, clock and data; array engine on sys_clk
// Notes: srst stands for a power cycle; pins pass two flip-flops
`timescale 1ns/1ps
`include "sfs_consts.svh"
module sfs_top #(
  parameter int SR_WRITE_CYC = `SFS_SR_WRITE_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 cs_n_pin,
  input  wire logic                 sclk_pin,
  input  wire logic                 si_pin,
  input  wire logic                 wp_n_pin,
  input  wire logic                 hold_n_pin,
  input  wire logic                 array_busy,
  input  wire logic [7:0]           rd_data,
  output logic                      so_out,
  output logic                      so_oe,
  output logic                      op_valid,
  output sfs_pkg::sfs_op_kind_t     op_kind,
  output logic [23:0]               mem_addr,
  output logic                      rd_req,
  output logic                      wr_valid,
  output logic [7:0]                wr_data,
  output logic                      pause_out,
  output logic                      reset_out,
  output logic [1:0]                drive_strength,
  output logic                      four_lane_out,
  output logic                      deep_pd,
  output sfs_pkg::sfs_prot_t        prot
);
  import sfs_pkg::*;

  logic [4:0]   meta_r, sync_r;
  logic         sclk_d_r, cs_d_r;
  logic         cs_s, sclk_s, si_s, wp_s, hold_s;
  logic         active, rise, fall, frame_end;
  logic [7:0]   rx_byte, tx_byte;
  logic         byte_done, tx_bit;
  logic [2:0]   bit_cnt;
  sfs_state_t   st_r, st_nxt;
  logic [7:0]   cmd_r, cmd_nxt;
  logic [2:0]   bidx_r, bidx_nxt;
  logic [23:0]  addr_r, addr_nxt;
  sfs_status_t  sr_r, sr_nxt;
  logic [11:0]  timer_r, timer_nxt;
  logic         last_erase_r, last_erase_nxt;
  logic         dpd_r, dpd_nxt;
  logic         block_lock_r, block_lock_nxt;
  logic         op_valid_r, op_valid_nxt;
  sfs_op_kind_t op_kind_r, op_kind_nxt;
  logic         rd_req_r, rd_req_nxt;
  logic         wr_valid_r, wr_valid_nxt;
  logic [7:0]   wr_data_r, wr_data_nxt;
  logic         so_r, so_oe_r, so_oe_nxt;
  logic         pause_r, pause_nxt, rstreq_r, rstreq_nxt;
  logic         wp_eff, sr_wr_ok, aligned, wel_go, out_phase;
  logic [2:0]   first_req;

  // Two-stage synchronisers, then one more stage for edges
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r   <= `SFS_SYNC_RESET;
      sync_r   <= `SFS_SYNC_RESET;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      meta_r   <= {cs_n_pin, sclk_pin, si_pin, wp_n_pin, hold_n_pin};
      sync_r   <= meta_r;
      sclk_d_r <= sync_r[3];
      cs_d_r   <= sync_r[4];
    end
  end

  assign cs_s      = sync_r[4];
  assign sclk_s    = sync_r[3];
  assign si_s      = sync_r[2];
  assign wp_s      = sync_r[1];
  assign hold_s    = sync_r[0];
  assign active    = !cs_s;
  assign rise      = active && sclk_s && !sclk_d_r && !pause_r;  // Latch on rising edge
  assign fall      = active && !sclk_s && sclk_d_r && !pause_r;
  assign frame_end = cs_s && !cs_d_r;

  sfs_shift u_shift (
    .clk       (sys_clk),
    .srst      (srst),
    .active    (active),
    .rise      (rise),
    .fall      (fall),
    .si        (si_s),
    .tx_byte   (tx_byte),
    .rx_byte   (rx_byte),
    .byte_done (byte_done),
    .bit_cnt   (bit_cnt),
    .tx_bit    (tx_bit)
  );

  // Protect pin only counts while the extra pins have their own roles
  assign wp_eff = sr_r.four_lane_enable ? 1'b1 : wp_s;
  // Status write permission from the guard bits
  assign sr_wr_ok = sr_r.write_latch && !sr_r.write_busy_flag &&
                    !sr_r.sr_guard_high && (!sr_r.sr_guard_low || wp_eff);
  assign aligned   = (bit_cnt == 3'h0);
  assign wel_go    = sr_r.write_latch && !sr_r.write_busy_flag;
  assign first_req = (cmd_r == `SFS_OP_READ) ? `SFS_IDX_ADDR_LAST : `SFS_IDX_DUMMY;

  // Output byte chosen by command
  always_comb begin
    case (cmd_r)
      `SFS_OP_RDSR_LO:   tx_byte = sr_r[7:0];
      `SFS_OP_RDSR_MID:  tx_byte = sr_r[15:8];
      `SFS_OP_RDSR_HI:   tx_byte = sr_r[23:16];
      `SFS_OP_READ,
      `SFS_OP_FAST_READ: tx_byte = rd_data;
      default:           tx_byte = 8'h00;
    endcase
  end

  // Data-out phase of read-type commands
  always_comb begin
    case (cmd_r)
      `SFS_OP_RDSR_LO, `SFS_OP_RDSR_MID, `SFS_OP_RDSR_HI: out_phase = 1'b1;
      `SFS_OP_READ:      out_phase = (bidx_r >= `SFS_IDX_ADDR_DONE);
      `SFS_OP_FAST_READ: out_phase = (bidx_r >= `SFS_IDX_FAST_DATA);
      default:           out_phase = 1'b0;
    endcase
  end

  // Framing, command decode and status update
  always_comb begin
    st_nxt         = st_r;
    cmd_nxt        = cmd_r;
    bidx_nxt       = bidx_r;
    addr_nxt       = addr_r;
    sr_nxt         = sr_r;
    last_erase_nxt = last_erase_r;
    dpd_nxt        = dpd_r;
    block_lock_nxt = block_lock_r;
    op_valid_nxt   = 1'b0;
    op_kind_nxt    = OPK_NONE;
    rd_req_nxt     = 1'b0;
    wr_valid_nxt   = 1'b0;
    wr_data_nxt    = wr_data_r;
    timer_nxt      = (timer_r != 12'h000) ? 12'(timer_r - 12'h001) : 12'h000;
    pause_nxt      = !sr_r.four_lane_enable && !sr_r.hold_reset_sel && !hold_s;
    rstreq_nxt     = !sr_r.four_lane_enable && sr_r.hold_reset_sel && !hold_s;
    so_oe_nxt      = active && (st_r == ST_BODY) && out_phase && !dpd_r;
    if (rstreq_r) begin
      block_lock_nxt = 1'b1;
    end
    if (st_r == ST_IDLE && active) begin
      st_nxt = ST_CMD;
    end
    if (byte_done) begin
      if (st_r == ST_CMD) begin
        cmd_nxt  = rx_byte;
        bidx_nxt = 3'h1;
        st_nxt   = ST_BODY;
      end else if (st_r == ST_BODY) begin
        if (bidx_r != 3'h7) begin
          bidx_nxt = 3'(bidx_r + 3'h1);
        end
        if (bidx_r <= `SFS_IDX_ADDR_LAST) begin
          addr_nxt = {addr_r[15:0], rx_byte};
        end
        if (cmd_r == `SFS_OP_READ || cmd_r == `SFS_OP_FAST_READ) begin
          if (bidx_r == first_req) begin
            rd_req_nxt = 1'b1;
          end else if (bidx_r > first_req) begin
            addr_nxt   = 24'(addr_r + 24'h000001);
            rd_req_nxt = 1'b1;
          end
        end
        if (cmd_r == `SFS_OP_PROGRAM && bidx_r >= `SFS_IDX_ADDR_DONE) begin
          wr_valid_nxt = 1'b1;
          wr_data_nxt  = rx_byte;
        end
      end
    end
    if (frame_end) begin
      st_nxt = ST_IDLE;
      if (st_r == ST_BODY && cmd_r == `SFS_OP_WAKE) begin
        dpd_nxt = 1'b0;
      end
      // Partial last byte rejects the command, latch kept
      if (st_r == ST_BODY && aligned && !dpd_r) begin
        case (cmd_r)
          `SFS_OP_WREN: sr_nxt.write_latch = 1'b1;
          `SFS_OP_WRDI: sr_nxt.write_latch = 1'b0;
          `SFS_OP_WRSR_LO: begin
            if (sr_wr_ok && bidx_r >= `SFS_IDX_WRSR_DONE) begin
              sr_nxt.sr_guard_low       = addr_r[7];
              sr_nxt.protect_range_bits = addr_r[6:2];
              sr_nxt.write_latch        = 1'b0;
              timer_nxt                 = 12'(SR_WRITE_CYC);
            end
          end
          `SFS_OP_WRSR_MID: begin
            if (sr_wr_ok && bidx_r >= `SFS_IDX_WRSR_DONE) begin
              sr_nxt.sr_guard_high         = addr_r[0];
              sr_nxt.four_lane_enable      = addr_r[1];
              sr_nxt.secure_area_lock_bits = sr_r.secure_area_lock_bits | addr_r[5:3];
              sr_nxt.protect_complement    = addr_r[6];
              sr_nxt.write_latch           = 1'b0;
              timer_nxt                    = 12'(SR_WRITE_CYC);
            end
          end
          `SFS_OP_WRSR_HI: begin
            if (sr_wr_ok && bidx_r >= `SFS_IDX_WRSR_DONE) begin
              sr_nxt.protect_scheme_select = addr_r[2];
              sr_nxt.drive_strength_field  = addr_r[6:5];
              sr_nxt.hold_reset_sel        = addr_r[7];
              sr_nxt.write_latch           = 1'b0;
              timer_nxt                    = 12'(SR_WRITE_CYC);
            end
          end
          `SFS_OP_PROGRAM: begin
            if (wel_go && bidx_r >= `SFS_IDX_FAST_DATA) begin
              op_valid_nxt       = 1'b1;
              op_kind_nxt        = OPK_PROG;
              last_erase_nxt     = 1'b0;
              sr_nxt.write_latch = 1'b0;
            end
          end
          `SFS_OP_ERASE_4K, `SFS_OP_ERASE_32K, `SFS_OP_ERASE_64K: begin
            if (wel_go && bidx_r == `SFS_IDX_ADDR_DONE) begin
              op_valid_nxt       = 1'b1;
              op_kind_nxt        = (cmd_r == `SFS_OP_ERASE_4K) ? OPK_ERASE_4K :
                                   (cmd_r == `SFS_OP_ERASE_32K) ? OPK_ERASE_32K : OPK_ERASE_64K;
              last_erase_nxt     = 1'b1;
              sr_nxt.write_latch = 1'b0;
            end
          end
          `SFS_OP_CHIP_A, `SFS_OP_CHIP_B: begin
            if (wel_go && bidx_r == 3'h1 && sr_r.protect_range_bits[2:0] == 3'h0 &&
                !sr_r.protect_complement) begin
              op_valid_nxt       = 1'b1;
              op_kind_nxt        = OPK_CHIP;
              last_erase_nxt     = 1'b1;
              sr_nxt.write_latch = 1'b0;
            end
          end
          `SFS_OP_DEEP_PD: dpd_nxt = 1'b1;
          `SFS_OP_SUSPEND: begin
            if (array_busy) begin
              sr_nxt.erase_paused_flag   = sr_r.erase_paused_flag | last_erase_r;
              sr_nxt.program_paused_flag = sr_r.program_paused_flag | !last_erase_r;
              op_valid_nxt               = 1'b1;
              op_kind_nxt                = OPK_SUSPEND;
            end
          end
          `SFS_OP_RESUME: begin
            if (sr_r.erase_paused_flag || sr_r.program_paused_flag) begin
              sr_nxt.erase_paused_flag   = 1'b0;
              sr_nxt.program_paused_flag = 1'b0;
              op_valid_nxt               = 1'b1;
              op_kind_nxt                = OPK_RESUME;
            end
          end
          default: sr_nxt.write_latch = sr_r.write_latch;
        endcase
      end
    end
    sr_nxt.write_busy_flag = array_busy || (timer_nxt != 12'h000);
  end

  // Register control state; srst is the power cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r         <= ST_IDLE;
      cmd_r        <= 8'h00;
      bidx_r       <= 3'h0;
      addr_r       <= 24'h000000;
      sr_r         <= '0;
      {sr_r.sr_guard_high, sr_r.sr_guard_low} <= `SFS_GUARD_RESET;
      sr_r.four_lane_enable      <= `SFS_QE_RESET;
      sr_r.protect_complement    <= `SFS_CMP_RESET;
      sr_r.secure_area_lock_bits <= `SFS_LB_RESET;
      sr_r.drive_strength_field  <= `SFS_DRV_RESET;
      if (sr_r.sr_guard_high && sr_r.sr_guard_low) begin
        sr_r <= {sr_r[23:16], 1'b0, sr_r[14:11], 1'b0, sr_r[9:2], 2'h0}; // Locked image kept, volatile bits cleared
      end
      timer_r      <= 12'h000;
      last_erase_r <= 1'b0;
      dpd_r        <= 1'b0;
      block_lock_r <= `SFS_BLOCK_LOCK_RESET;
      op_valid_r   <= 1'b0;
      op_kind_r    <= OPK_NONE;
      rd_req_r     <= 1'b0;
      wr_valid_r   <= 1'b0;
      wr_data_r    <= 8'h00;
      so_r         <= 1'b0;
      so_oe_r      <= 1'b0;
      pause_r      <= 1'b0;
      rstreq_r     <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      cmd_r        <= cmd_nxt;
      bidx_r       <= bidx_nxt;
      addr_r       <= addr_nxt;
      sr_r         <= sr_nxt;
      timer_r      <= timer_nxt;
      last_erase_r <= last_erase_nxt;
      dpd_r        <= dpd_nxt;
      block_lock_r <= block_lock_nxt;
      op_valid_r   <= op_valid_nxt;
      op_kind_r    <= op_kind_nxt;
      rd_req_r     <= rd_req_nxt;
      wr_valid_r   <= wr_valid_nxt;
      wr_data_r    <= wr_data_nxt;
      so_r         <= tx_bit;
      so_oe_r      <= so_oe_nxt;
      pause_r      <= pause_nxt;
      rstreq_r     <= rstreq_nxt;
    end
  end

  // Outputs straight from flops
  assign so_out         = so_r;
  assign so_oe          = so_oe_r;
  assign op_valid       = op_valid_r;
  assign op_kind        = op_kind_r;
  assign mem_addr       = addr_r;
  assign rd_req         = rd_req_r;
  assign wr_valid       = wr_valid_r;
  assign wr_data        = wr_data_r;
  assign pause_out      = pause_r;
  assign reset_out      = rstreq_r;
  assign drive_strength = sr_r.drive_strength_field;
  assign four_lane_out  = sr_r.four_lane_enable;
  assign deep_pd        = dpd_r;
  assign prot           = {sr_r.protect_scheme_select, sr_r.protect_complement,
                           sr_r.protect_range_bits, sr_r.secure_area_lock_bits, block_lock_r};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_end_cmd(logic [7:0] op);
    frame_end && st_r == ST_BODY && aligned && !dpd_r && cmd_r == op;
  endsequence

  chk_suspend_erase: assert property (s_end_cmd(`SFS_OP_SUSPEND) ##0 (array_busy && last_erase_r)
    |=> sr_r.erase_paused_flag && op_kind_r == OPK_SUSPEND)
    else $error("erase suspend did not set paused flag");
  chk_resume_clear: assert property (s_end_cmd(`SFS_OP_RESUME)
    |=> !sr_r.erase_paused_flag && !sr_r.program_paused_flag)
    else $error("resume left a paused flag set");
  chk_unaligned_drop: assert property ((frame_end && st_r == ST_BODY && !aligned)
    |=> !op_valid_r && $stable(sr_r.write_latch))
    else $error("unaligned frame changed latch or issued an operation");
  chk_sr_locked: assert property ((frame_end && !sr_wr_ok)
    |=> $stable(sr_r.protect_range_bits) && $stable(sr_r.sr_guard_low) && $stable(sr_r.four_lane_enable))
    else $error("protected status register was written");
  chk_latch_needed: assert property ((op_valid_r && op_kind_r inside {OPK_PROG, OPK_ERASE_4K,
    OPK_ERASE_32K, OPK_ERASE_64K, OPK_CHIP}) |-> $past(sr_r.write_latch) && !sr_r.write_latch)
    else $error("write operation without write latch");
  chk_sr_write_busy: assert property ($rose(timer_r != 12'h000) |-> sr_r.write_busy_flag [*8])
    else $error("busy flag dropped during status write");
  chk_chip_guard: assert property ((op_valid_r && op_kind_r == OPK_CHIP)
    |-> $past(sr_r.protect_range_bits[2:0]) == 3'h0 && !$past(sr_r.protect_complement))
    else $error("chip erase issued with protection set");
  chk_pin_roles: assert property ((sr_r.four_lane_enable && $past(sr_r.four_lane_enable))
    |-> !pause_r && !reset_out)
    else $error("pause or reset role active with quad enabled");
  chk_block_lock: assert property (rstreq_r |=> block_lock_r)
    else $error("block locks not set after reset pin");

endmodule

// [tb/sfs_host.sv]
// Purpose: host controller model driving the serial link
// Assumes: serial clock half period 160 ns, idle low
// Notes: si shows the inverse of its last bit while idle
`timescale 1ns/1ps
module sfs_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so
);
  // Link idle at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // One frame from just after a clock edge; so sampled 1 ns before an edge
  task automatic xfer(input logic [63:0] tx, input int n, output logic [7:0] rx);
    @(posedge clk) #1 cs_n = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #160 sclk = 1'b1;
      #158 rx = {rx[6:0], so};
      #2 sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    si = ~si;
    #320;
  endtask
endmodule

// [tb/sfs_tb_top.sv]
// Purpose: status and framing checks through serial frames
// Assumes: status write time cut to 8 cycles
// Notes: bench drives both extra pins, never strapped
`timescale 1ns/1ps
module sfs_tb_top;
  import sfs_pkg::*;
  logic clk = 1'b0, srst = 1'b1, wp_n = 1'b1, hold_n = 1'b1, busy = 1'b0; // Pins driven, not strapped
  logic [7:0] rd_data = 8'hA5, rx, wrd;
  logic cs_n, sclk, si, so, so_oe, opv, rdq, wrv, pause, rst_o, quad, dpd;
  logic [1:0] drive;
  logic [23:0] addr;
  sfs_op_kind_t op_kind;
  sfs_prot_t prot;
  logic [2:0] kind;
  int fails = 0, checks = 0, cyc = 0, nops = 0;

  always #20 clk = ~clk;

  sfs_host i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  sfs_top #(.SR_WRITE_CYC(8)) i_dut (.sys_clk(clk), .srst(srst), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .si_pin(si), .wp_n_pin(wp_n), .hold_n_pin(hold_n), .array_busy(busy), .rd_data(rd_data),
    .so_out(so), .so_oe(so_oe), .op_valid(opv), .op_kind(op_kind), .mem_addr(addr), .rd_req(rdq),
    .wr_valid(wrv), .wr_data(wrd), .pause_out(pause), .reset_out(rst_o), .drive_strength(drive),
    .four_lane_out(quad), .deep_pd(dpd), .prot(prot));

  // Array read model, issued operations and hang limit
  always @(posedge clk) begin
    if (rdq === 1'b1) begin
      rd_data <= addr[7:0] ^ 8'hA5;
    end
    if (opv === 1'b1) begin
      nops++;
      kind = op_kind;
    end
    if (++cyc == 20000) begin
      fails++;
      results;
    end
  end

  task automatic results;
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Status read, masked compare
  task automatic rd(input logic [7:0] op, input logic [7:0] exp, input logic [7:0] m);
    i_host.xfer({op, 8'h00}, 16, rx);
    cmp(rx & m, exp);
  endtask

  // Latch set, status write, wait out busy time
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    i_host.xfer(8'h06, 8, rx);
    i_host.xfer({op, d}, 16, rx);
    repeat (12) @(posedge clk);
  endtask

  task automatic pin_hold_low;
    @(posedge clk) #1 hold_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Reset pulse standing in for a power cycle
  task automatic pwr_cycle;
    @(posedge clk) #1 srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h05, 8'h00, 8'hFF);
    rd(8'h35, 8'h00, 8'hFF);
    rd(8'h15, 8'h40, 8'hFF);
    cmp(prot, 11'h001);
    i_host.xfer({8'h01, 8'h1C}, 16, rx);
    rd(8'h05, 8'h00, 8'hFF);
    i_host.xfer({8'h06, 4'h0}, 12, rx);
    rd(8'h05, 8'h00, 8'hFF);
    i_host.xfer(8'h06, 8, rx);
    rd(8'h05, 8'h02, 8'hFF);
    i_host.xfer({8'h01, 8'h1C}, 16, rx);
    repeat (12) @(posedge clk);
    rd(8'h05, 8'h1C, 8'hFC);
    cmp(prot, 11'h071);
    i_host.xfer(8'h06, 8, rx);
    i_host.xfer(8'h60, 8, rx);
    cmp(nops[23:0], 24'h000000);
    wr(8'h01, 8'h80);
    @(posedge clk) #1 wp_n = 1'b0;
    wr(8'h01, 8'h00);
    rd(8'h05, 8'h80, 8'hFC);
    i_host.xfer(8'h06, 8, rx);
    i_host.xfer(8'h60, 8, rx);
    repeat (6) @(posedge clk);
    cmp({nops[7:0], 5'h00, kind}, {8'h01, 5'h00, 3'h5});
    @(posedge clk) #1 busy = 1'b1;
    i_host.xfer(8'h75, 8, rx);
    @(posedge clk) #1 busy = 1'b0;
    rd(8'h35, 8'h80, 8'hFF);
    cmp(kind, 3'h6);
    i_host.xfer(8'h7A, 8, rx);
    rd(8'h35, 8'h00, 8'hFF);
    cmp(kind, 3'h7);
    @(posedge clk) #1 wp_n = 1'b1;
    wr(8'h01, 8'h00);
    wr(8'h31, 8'h01);
    wr(8'h01, 8'h1C);
    rd(8'h05, 8'h00, 8'hFC);
    pwr_cycle;
    rd(8'h35, 8'h00, 8'hFF);
    rd(8'h05, 8'h00, 8'hFF);
    wr(8'h11, 8'h80);
    cmp(drive, 2'h0);
    pin_hold_low;
    cmp(rst_o, 1'b1);
    hold_n = 1'b1;
    wr(8'h31, 8'h08);
    wr(8'h31, 8'h00);
    rd(8'h35, 8'h08, 8'hFF);
    wr(8'h31, 8'h02);
    cmp(quad, 1'b1);
    pin_hold_low;
    cmp({rst_o, pause}, 2'h0);
    hold_n = 1'b1;
    i_host.xfer({8'h0B, 24'h012345, 8'h00, 8'h00}, 48, rx);
    cmp(rx, 8'hE0);
    i_host.xfer({8'h03, 24'h000010, 8'h00}, 40, rx);
    cmp(rx, 8'hB5);
    i_host.xfer(8'h06, 8, rx);
    i_host.xfer({8'h02, 24'h000100, 8'h5A, 3'h0}, 43, rx);
    rd(8'h05, 8'h02, 8'hFF);
    i_host.xfer({8'h02, 24'h000100, 8'hC3}, 40, rx);
    cmp({wrd, 5'h00, kind}, {8'hC3, 5'h00, 3'h1});
    i_host.xfer(8'hB9, 8, rx);
    cmp(dpd, 1'b1);
    i_host.xfer(8'hAB, 8, rx);
    cmp(dpd, 1'b0);
    wr(8'h01, 8'h80);
    wr(8'h31, 8'h01);
    wr(8'h01, 8'h00);
    rd(8'h05, 8'h80, 8'hFC);
    pwr_cycle;
    wr(8'h01, 8'h00);
    rd(8'h05, 8'h80, 8'hFC);
    results;
  end
endmodule
